// *** efmfw_params.svh ***
// Constants for the error flag mirror and firmware RAM block
`ifndef EFMFW_PARAMS_SVH
`define EFMFW_PARAMS_SVH
// Register word indices (byte address divided by four)
`define EFMFW_IDX_NEG_VOL_INT 10'h100
`define EFMFW_IDX_NEG_VOL_FRAC 10'h101
`define EFMFW_IDX_ERR_CNT_12 10'h105
`define EFMFW_IDX_ERR_CNT_34 10'h106
`define EFMFW_IDX_WDOG_CODE 10'h16c
`define EFMFW_IDX_FW_STATUS 10'h180
`define EFMFW_IDX_IRQ_STATUS 10'h181
`define EFMFW_IDX_IRQ_MASK 10'h182
`define EFMFW_IDX_CONTROL 10'h183
// Codes
`define EFMFW_WDOG_DISABLE_CODE 32'h48dba399
`define EFMFW_RESTORE_OFF_CODE 32'h00000000
// Hardware error word bit positions
`define EFMFW_HW_TEMP_TMO 8
`define EFMFW_HW_SEQ_TMO 9
`define EFMFW_HW_EEPROM_ACK 10
`define EFMFW_HW_UNUSED 11
`define EFMFW_HW_CS_FIRST 12
`define EFMFW_STATUS_MIRROR_LSB 24
// Control register bits
`define EFMFW_CTRL_VOL_ERR_CLR 0
`define EFMFW_CTRL_RESET_VAL 32'h00000000
`endif

// *** efmfw_pkg.sv ***
// Types for the error flag mirror and firmware RAM block
package efmfw_pkg;
  typedef logic [31:0] efmfw_word_t;
  typedef logic [7:0] efmfw_mirror_t;
endpackage

// *** efmfw_top.sv ***
// Error flag mirror, firmware RAM cells and Wishbone register slave
`timescale 1ns/1ps
`include "efmfw_params.svh"

// How it works
// - Bit 24 copies hardware temp timeout flag
// - No pause time forces temp timeout set
// - Bit 25 copies sequencer busy timeout flag
// - Bit 26 copies EEPROM acknowledge failure flag
// - Bit 30 copies user code checksum
// - Bit 31 copies vendor code checksum
// - Recall copies flash words into RAM cells
// - Cell 0x100 holds negative volume integer
// - Cell 0x101 holds negative volume fraction
// - Cell 0x105 packs error counts two, one
// - Cell 0x106 packs error counts four, three
// - Watchdog off only on disable code
// - Vendor firmware: watchdog on, zero stops restore
// - Volume error copy cleared only by software
module efmfw_top
  import efmfw_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [11:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  input wire logic [15:0] i_hardware_error_word,
  input wire logic i_error_word_clear,
  input wire logic i_pause_time_zero,
  input wire logic i_volume_error_event,
  input wire logic i_vendor_firmware,
  input wire logic i_neg_limit_enabled,
  input wire logic i_recall,
  input wire logic [31:0] i_flash_neg_vol_int,
  input wire logic [31:0] i_flash_neg_vol_frac,
  input wire logic [31:0] i_flash_err_cnt_12,
  input wire logic [31:0] i_flash_err_cnt_34,
  input wire logic [31:0] i_flash_wdog_code,
  output logic o_watchdog_enable,
  output logic o_config_restore_enable,
  output logic o_neg_volume_active,
  output logic o_volume_error_flag,
  output logic o_irq
);

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  logic bus_req;
  logic bus_wr;
  logic bus_rd;
  logic [9:0] word_idx;
  efmfw_word_t wmask;

  // A request is answered one cycle after it is seen
  assign bus_req = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  assign bus_wr = bus_req & i_wb_we;
  assign bus_rd = bus_req & ~i_wb_we;
  assign word_idx = i_wb_adr[11:2];
  assign wmask = {{8{i_wb_sel[3]}}, {8{i_wb_sel[2]}}, {8{i_wb_sel[1]}}, {8{i_wb_sel[0]}}};

  // ----------------------------------------
  // State
  // ----------------------------------------
  efmfw_word_t neg_vol_int;
  efmfw_word_t neg_vol_frac;
  efmfw_word_t err_cnt_12;
  efmfw_word_t err_cnt_34;
  efmfw_word_t wdog_code;
  efmfw_mirror_t mirror;
  logic volume_error_flag;
  logic [3:0] irq_status;
  logic [3:0] irq_mask;
  logic [31:0] rd_data;
  logic ack;
  efmfw_word_t next_neg_vol_int;
  efmfw_word_t next_neg_vol_frac;
  efmfw_word_t next_err_cnt_12;
  efmfw_word_t next_err_cnt_34;
  efmfw_word_t next_wdog_code;
  efmfw_mirror_t next_mirror;
  logic next_volume_error_flag;
  logic [3:0] next_irq_status;
  logic [3:0] next_irq_mask;
  logic [31:0] next_rd_data;
  logic next_ack;

  // ----------------------------------------
  // Mirror capture
  // ----------------------------------------
  wire efmfw_mirror_t captured;
  efmfw_mirror_t flag_byte;

  // Upper flag byte; a missing pause time reads as a temperature timeout
  always_comb
  begin
    flag_byte = i_hardware_error_word[15:8];
    flag_byte[`EFMFW_HW_TEMP_TMO - 8] = i_hardware_error_word[`EFMFW_HW_TEMP_TMO] | i_pause_time_zero;
  end

  // One capture lane per mirrored bit; the unused lane is tied low
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_lane
      if (gi == `EFMFW_HW_UNUSED - 8)
      begin : g_unused
        assign captured[gi] = 1'b0;
      end
      else
      begin : g_copy
        assign captured[gi] = flag_byte[gi];
      end
    end
  endgenerate

  // ----------------------------------------
  // Shared decode
  // ----------------------------------------
  logic [3:0] events;
  logic sw_vol_clr;
  logic irq_status_rd;
  logic irq_mask_wr;
  efmfw_word_t fw_status;

  assign fw_status = {mirror, 24'h000000};
  assign sw_vol_clr = bus_wr & (word_idx == `EFMFW_IDX_CONTROL) & i_wb_sel[0] & i_wb_dat[`EFMFW_CTRL_VOL_ERR_CLR];
  assign irq_status_rd = bus_rd & (word_idx == `EFMFW_IDX_IRQ_STATUS);
  assign irq_mask_wr = bus_wr & (word_idx == `EFMFW_IDX_IRQ_MASK);
  // Events: temp/seq timeout, EEPROM ack, any checksum, volume error
  assign events = {i_volume_error_event,
                   |captured[7:4] & i_error_word_clear,
                   captured[2] & i_error_word_clear,
                   |captured[1:0] & i_error_word_clear};

  // ----------------------------------------
  // Firmware RAM cells
  // ----------------------------------------
  // Byte-lane writes; a recall in the same cycle overwrites every cell
  always_comb
  begin
    next_neg_vol_int = neg_vol_int;
    next_neg_vol_frac = neg_vol_frac;
    next_err_cnt_12 = err_cnt_12;
    next_err_cnt_34 = err_cnt_34;
    next_wdog_code = wdog_code;
    if (bus_wr)
    begin
      unique case (word_idx)
        `EFMFW_IDX_NEG_VOL_INT: next_neg_vol_int = (neg_vol_int & ~wmask) | (i_wb_dat & wmask);
        `EFMFW_IDX_NEG_VOL_FRAC: next_neg_vol_frac = (neg_vol_frac & ~wmask) | (i_wb_dat & wmask);
        `EFMFW_IDX_ERR_CNT_12: next_err_cnt_12 = (err_cnt_12 & ~wmask) | (i_wb_dat & wmask);
        `EFMFW_IDX_ERR_CNT_34: next_err_cnt_34 = (err_cnt_34 & ~wmask) | (i_wb_dat & wmask);
        `EFMFW_IDX_WDOG_CODE: next_wdog_code = (wdog_code & ~wmask) | (i_wb_dat & wmask);
        default: next_wdog_code = wdog_code;
      endcase
    end
    if (i_recall)
    begin
      next_neg_vol_int = i_flash_neg_vol_int;
      next_neg_vol_frac = i_flash_neg_vol_frac;
      next_err_cnt_12 = i_flash_err_cnt_12;
      next_err_cnt_34 = i_flash_err_cnt_34;
      next_wdog_code = i_flash_wdog_code;
    end
  end

  // Cell storage
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      neg_vol_int <= 32'h00000000;
      neg_vol_frac <= 32'h00000000;
      err_cnt_12 <= 32'h00000000;
      err_cnt_34 <= 32'h00000000;
      wdog_code <= 32'h00000000;
    end
    else
    begin
      neg_vol_int <= next_neg_vol_int;
      neg_vol_frac <= next_neg_vol_frac;
      err_cnt_12 <= next_err_cnt_12;
      err_cnt_34 <= next_err_cnt_34;
      wdog_code <= next_wdog_code;
    end
  end

  // ----------------------------------------
  // Status mirror
  // ----------------------------------------
  // Take the flag byte in the very cycle the error word is wiped
  always_comb
  begin
    next_mirror = mirror;
    if (i_error_word_clear)
      next_mirror = captured;
  end

  // Mirror storage
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
      mirror <= 8'h00;
    else
      mirror <= next_mirror;
  end

  // ----------------------------------------
  // Volume error copy
  // ----------------------------------------
  // Sticky until software clears it; a new event wins over the clear
  always_comb
  begin
    next_volume_error_flag = (volume_error_flag & ~sw_vol_clr) | i_volume_error_event;
  end

  // Volume error storage
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
      volume_error_flag <= 1'b0;
    else
      volume_error_flag <= next_volume_error_flag;
  end

  // ----------------------------------------
  // Interrupt status and mask
  // ----------------------------------------
  // Reading status clears it, but an event in that cycle still sets
  always_comb
  begin
    next_irq_mask = irq_mask;
    next_irq_status = irq_status;
    if (irq_mask_wr)
      next_irq_mask = (irq_mask & ~wmask[3:0]) | (i_wb_dat[3:0] & wmask[3:0]);
    if (irq_status_rd)
      next_irq_status = 4'h0;
    next_irq_status = next_irq_status | events;
  end

  // Interrupt storage
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      irq_status <= 4'h0;
      irq_mask <= 4'h0;
    end
    else
    begin
      irq_status <= next_irq_status;
      irq_mask <= next_irq_mask;
    end
  end

  // ----------------------------------------
  // Bus response
  // ----------------------------------------
  // Read mux; data is held until the next read, unmapped words read zero
  always_comb
  begin
    next_rd_data = rd_data;
    next_ack = bus_req;
    if (bus_rd)
    begin
      unique case (word_idx)
        `EFMFW_IDX_NEG_VOL_INT: next_rd_data = neg_vol_int;
        `EFMFW_IDX_NEG_VOL_FRAC: next_rd_data = neg_vol_frac;
        `EFMFW_IDX_ERR_CNT_12: next_rd_data = err_cnt_12;
        `EFMFW_IDX_ERR_CNT_34: next_rd_data = err_cnt_34;
        `EFMFW_IDX_WDOG_CODE: next_rd_data = wdog_code;
        `EFMFW_IDX_FW_STATUS: next_rd_data = fw_status;
        `EFMFW_IDX_IRQ_STATUS: next_rd_data = {28'h0000000, irq_status};
        `EFMFW_IDX_IRQ_MASK: next_rd_data = {28'h0000000, irq_mask};
        `EFMFW_IDX_CONTROL: next_rd_data = {31'h00000000, volume_error_flag};
        default: next_rd_data = 32'h00000000;
      endcase
    end
  end

  // Response storage; ack is a single-cycle pulse
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      rd_data <= 32'h00000000;
      ack <= 1'b0;
    end
    else
    begin
      rd_data <= next_rd_data;
      ack <= next_ack;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Watchdog and restore decisions from the code word
  assign o_watchdog_enable = i_vendor_firmware | (wdog_code != `EFMFW_WDOG_DISABLE_CODE);
  assign o_config_restore_enable = ~(i_vendor_firmware & (wdog_code == `EFMFW_RESTORE_OFF_CODE));
  assign o_neg_volume_active = i_neg_limit_enabled;
  assign o_volume_error_flag = volume_error_flag;
  assign o_irq = |(irq_status & irq_mask);
  assign o_wb_ack = ack;
  assign o_wb_dat = rd_data;

endmodule

// *** efmfw_asserts.sv ***
// Assertion checker for the error flag mirror and firmware RAM block
`timescale 1ns/1ps
module efmfw_asserts
(
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [11:0] i_wb_adr,
  input wire logic [31:0] o_wb_dat,
  input wire logic o_wb_ack,
  input wire logic i_volume_error_event,
  input wire logic i_vendor_firmware,
  input wire logic i_neg_limit_enabled,
  input wire logic i_recall,
  input wire logic [31:0] i_flash_wdog_code,
  input wire logic o_watchdog_enable,
  input wire logic o_config_restore_enable,
  input wire logic o_neg_volume_active,
  input wire logic o_volume_error_flag
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rstn);
  // Bus request taken and flash load of a given code word
  sequence s_req;
    i_wb_cyc && i_wb_stb && !o_wb_ack;
  endsequence
  sequence s_load(logic [31:0] code);
    i_recall && i_flash_wdog_code == code;
  endsequence
  a_ack_pulse: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack longer than one cycle");
  a_ack_answer: assert property (s_req |=> o_wb_ack)
    else $error("no ack one cycle after request");
  a_unmapped_zero: assert property (s_req ##0 (!i_wb_we && i_wb_adr == 12'hffc) |=> o_wb_dat == 32'h0)
    else $error("unmapped read not zero");
  a_neg_active: assert property (o_neg_volume_active == i_neg_limit_enabled)
    else $error("negative volume active mismatch");
  a_vol_set: assert property (i_volume_error_event |=> o_volume_error_flag)
    else $error("volume error not set");
  a_vol_hold: assert property (o_volume_error_flag && !(i_wb_cyc && i_wb_we) |=> o_volume_error_flag)
    else $error("volume error cleared by itself");
  a_wdog_vendor: assert property (i_vendor_firmware |-> o_watchdog_enable)
    else $error("watchdog off with vendor firmware");
  a_restore_plain: assert property (!i_vendor_firmware |-> o_config_restore_enable)
    else $error("restore off without vendor firmware");
  a_wdog_code: assert property (s_load(32'h48dba399) ##1 !i_vendor_firmware |-> !o_watchdog_enable)
    else $error("disable code did not stop watchdog");
  a_restore_zero: assert property (s_load(32'h0) ##1 i_vendor_firmware |-> !o_config_restore_enable)
    else $error("zero code did not stop restore");
endmodule
bind efmfw_top efmfw_asserts u_asserts (.*);

// *** efmfw_host.sv ***
// Host controller model: Wishbone master reaching the firmware cells
`timescale 1ns/1ps
`include "efmfw_params.svh"
module efmfw_host
(
  input wire logic i_clk,
  input wire logic i_ack,
  input wire logic [31:0] i_rdat,
  output logic o_cyc,
  output logic o_stb,
  output logic o_we,
  output logic [11:0] o_adr,
  output logic [3:0] o_sel,
  output logic [31:0] o_dat
);
  int tmo = 0;
  initial {o_cyc, o_stb, o_we, o_adr, o_sel, o_dat} = '0;
  // One classic cycle; released lines show the inverse of the last value
  task automatic xfer(input logic we, input logic [9:0] idx, input logic [31:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    {o_cyc, o_stb, o_we, o_adr, o_sel, o_dat} <= {2'b11, we, idx, 2'b00, 4'hf, wd};
    do
    begin
      @(posedge i_clk);
      n++;
    end while (i_ack !== 1'b1 && n < 50);
    rd = i_rdat;
    if (n >= 50) tmo++;
    {o_cyc, o_stb, o_adr, o_dat} <= {2'b00, ~o_adr, ~o_dat};
    @(posedge i_clk);
  endtask
  // Start-up writes of the host
  task automatic setup();
    logic [31:0] d;
    xfer(1'b1, `EFMFW_IDX_WDOG_CODE, 32'h95659c6a, d);
    xfer(1'b1, `EFMFW_IDX_ERR_CNT_12, 32'h0, d);
    xfer(1'b1, `EFMFW_IDX_ERR_CNT_34, 32'h0, d);
  endtask
endmodule

// *** efmfw_top_tb.sv ***
// Testbench for the error flag mirror and firmware RAM block
`timescale 1ns/1ps
`include "efmfw_params.svh"
module efmfw_top_tb;
  import efmfw_pkg::*;
  logic i_clk, i_rstn, i_wb_cyc, i_wb_stb, i_wb_we, o_wb_ack, i_error_word_clear, i_pause_time_zero;
  logic i_volume_error_event, i_vendor_firmware, i_neg_limit_enabled, i_recall, o_watchdog_enable;
  logic o_config_restore_enable, o_neg_volume_active, o_volume_error_flag, o_irq;
  logic [11:0] i_wb_adr;
  logic [3:0] i_wb_sel;
  logic [15:0] i_hardware_error_word;
  efmfw_word_t i_wb_dat, o_wb_dat, i_flash_neg_vol_int, i_flash_neg_vol_frac, i_flash_err_cnt_12;
  efmfw_word_t i_flash_err_cnt_34, i_flash_wdog_code, rdat;
  int num_errors = 0;
  int comparisons = 0;
  efmfw_top dut (.*);
  efmfw_host host (.i_clk(i_clk), .i_ack(o_wb_ack), .i_rdat(o_wb_dat), .o_cyc(i_wb_cyc), .o_stb(i_wb_stb),
    .o_we(i_wb_we), .o_adr(i_wb_adr), .o_sel(i_wb_sel), .o_dat(i_wb_dat));
  initial
  begin
    i_clk = 0;
    forever #4 i_clk = ~i_clk;
  end
  task automatic chk(input efmfw_word_t got, input efmfw_word_t exp);
    comparisons++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Bus access with timeout check, and read with compare
  task automatic xf(input logic we, input logic [9:0] idx, input efmfw_word_t wd);
    host.xfer(we, idx, wd, rdat);
    if (host.tmo != 0)
    begin
      num_errors++;
      stop_test();
    end
  endtask
  task automatic rd(input logic [9:0] idx, input efmfw_word_t exp);
    xf(1'b0, idx, 32'h0);
    chk(rdat, exp);
  endtask
  // Host start-up writes, cell read-back and unmapped read
  task automatic t_cells();
    host.setup();
    rd(`EFMFW_IDX_WDOG_CODE, 32'h95659c6a);
    chk({31'h0, o_watchdog_enable}, 32'h1);
    rd(`EFMFW_IDX_ERR_CNT_12, 32'h0);
    rd(`EFMFW_IDX_ERR_CNT_34, 32'h0);
    xf(1'b1, `EFMFW_IDX_NEG_VOL_INT, 32'h12345678);
    rd(`EFMFW_IDX_NEG_VOL_INT, 32'h12345678);
    rd(10'h3ff, 32'h0);
  endtask
  // Recall overwrites cells; code word drives watchdog and restore
  task automatic t_recall();
    {i_flash_neg_vol_int, i_flash_neg_vol_frac} <= {32'h00000011, 32'h80000000};
    {i_flash_err_cnt_12, i_flash_err_cnt_34} <= {32'h00020001, 32'h00040003};
    i_flash_wdog_code <= `EFMFW_WDOG_DISABLE_CODE;
    i_recall <= 1'b1;
    @(posedge i_clk);
    i_recall <= 1'b0;
    rd(`EFMFW_IDX_NEG_VOL_INT, 32'h00000011);
    rd(`EFMFW_IDX_NEG_VOL_FRAC, 32'h80000000);
    rd(`EFMFW_IDX_ERR_CNT_12, 32'h00020001);
    rd(`EFMFW_IDX_ERR_CNT_34, 32'h00040003);
    chk({31'h0, o_watchdog_enable}, 32'h0);
    i_vendor_firmware <= 1'b1;
    i_flash_wdog_code <= `EFMFW_RESTORE_OFF_CODE;
    i_recall <= 1'b1;
    @(posedge i_clk);
    i_recall <= 1'b0;
    rd(`EFMFW_IDX_WDOG_CODE, 32'h0);
    chk({30'h0, o_watchdog_enable, o_config_restore_enable}, 32'h2);
    i_vendor_firmware <= 1'b0;
  endtask
  // Error word capture, unused bit, forced bit, interrupt set and clear
  task automatic t_mirror();
    xf(1'b1, `EFMFW_IDX_IRQ_MASK, 32'h1);
    i_hardware_error_word <= 16'hff00;
    i_error_word_clear <= 1'b1;
    @(posedge i_clk);
    {i_error_word_clear, i_hardware_error_word} <= '0;
    rd(`EFMFW_IDX_FW_STATUS, 32'hf7000000);
    chk({31'h0, o_irq}, 32'h1);
    rd(`EFMFW_IDX_IRQ_STATUS, 32'h7);
    chk({31'h0, o_irq}, 32'h0);
    {i_pause_time_zero, i_error_word_clear} <= 2'b11;
    @(posedge i_clk);
    i_error_word_clear <= 1'b0;
    rd(`EFMFW_IDX_FW_STATUS, 32'h01000000);
  endtask
  // Volume error copy stays until software clears it
  task automatic t_volerr();
    {i_volume_error_event, i_neg_limit_enabled} <= 2'b11;
    @(posedge i_clk);
    i_volume_error_event <= 1'b0;
    repeat (4) @(posedge i_clk);
    rd(`EFMFW_IDX_CONTROL, 32'h1);
    chk({31'h0, o_neg_volume_active}, 32'h1);
    xf(1'b1, `EFMFW_IDX_CONTROL, 32'h1);
    chk({31'h0, o_volume_error_flag}, 32'h0);
  endtask
  initial
  begin
    {i_rstn, i_error_word_clear, i_pause_time_zero, i_volume_error_event, i_vendor_firmware} = '0;
    {i_neg_limit_enabled, i_recall, i_hardware_error_word} = '0;
    {i_flash_neg_vol_int, i_flash_neg_vol_frac, i_flash_err_cnt_12, i_flash_err_cnt_34, i_flash_wdog_code} = '0;
    repeat (3) @(posedge i_clk);
    i_rstn <= 1'b1;
    @(posedge i_clk);
    t_cells();
    t_recall();
    t_mirror();
    t_volerr();
    stop_test();
  end
endmodule
